// ===== logic/dhpuc_top.sv
`timescale 1ns/1ns
// Overview of operation
// (R1) write on strobe rising edge with chip select low
// (R2) chain enable high selects spi daisy chain
// (R3) two address pins form bus address
// (R4) twelve bit data, line eleven is msb
// (R5) six select lines pick one of forty
// (R6) register type picks data, offset, gain, sfr
// (R7) serial out shifts on rising serial clock
// (R8) bank select picks a or b in toggle
// (R9) load flips output between a and b
// (R10) two data registers; a outside toggle mode
// (R11) busy low while calculating; no output update
// (R12) load low while idle updates outputs
// (R13) load during calculation is stored for later
// (R14) reset: busy low, interface off, loads dropped
// (R15) clear falling edge loads clear code, 35us
// (R16) reset falling edge restores defaults, 270us
// (R17) busy high after reset; pin then ignored
// (R18) chip select level sensitive, active low
// (R19) iface select high serial, low parallel
// (R20) serial input sampled on falling serial clock
// (R21) several loads collapse into one update
module dhpuc_top #(
	parameter int RESET_CNT = dhpuc_pkg::RESET_CYCLES,  // shortenable reset sequence
	parameter int CLEAR_CNT = dhpuc_pkg::CLEAR_CYCLES   // shortenable clear period
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   nrst,
	// mode pins
	input  wire logic                   iface_select,
	input  wire logic                   spi_not_twowire,
	input  wire logic                   chain_enable,
	input  wire logic                   bus_addr_pin_low,
	input  wire logic                   bus_addr_pin_high,
	// parallel write port
	input  wire logic                   cs_n,
	input  wire logic                   wr_n,
	input  wire logic [11:0]            par_data_bus,
	input  wire logic [5:0]             channel_select,
	input  wire logic [1:0]             reg_type_select,
	input  wire logic                   bank_b_select,
	// serial pins
	input  wire logic                   serial_clk,
	input  wire logic                   serial_in,
	output logic                        serial_out,
	output logic                        serial_out_en,
	// hardware control
	input  wire logic                   load_outputs_n,
	input  wire logic                   clear_to_code_n,
	input  wire logic                   reset_n,
	// status and results
	output logic                        busy_n,
	output logic                        daisy_chain_mode,
	output logic [1:0]                  bus_address,
	output logic [11:0]                 output_word [dhpuc_pkg::NUM_CHAN]
);
	// both counts share one down-counter, so each must fit it
	if (RESET_CNT < 1 || RESET_CNT >= (1 << dhpuc_pkg::CNT_W) ||
	    CLEAR_CNT < 1 || CLEAR_CNT >= (1 << dhpuc_pkg::CNT_W))
	begin : g_bad_count
		$error("dhpuc_top: count parameter out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// storage
	logic [11:0] input_word  [dhpuc_pkg::NUM_CHAN];  // data register a
	logic [11:0] data_b      [dhpuc_pkg::NUM_CHAN];  // data register b
	logic [11:0] offset_reg  [dhpuc_pkg::NUM_CHAN];
	logic [11:0] gain_reg    [dhpuc_pkg::NUM_CHAN];
	logic [11:0] clear_code;                          // clear code sfr
	logic        toggle_mode;                         // toggle enable sfr
	logic        show_b;                              // toggle phase
	// edge history
	logic        wr_n_d;
	logic        load_d;
	logic        clear_d;
	logic        rst_pin_d;
	logic        sclk_d;
	// sequencer
	dhpuc_pkg::dhpuc_state_type state;
	dhpuc_pkg::dhpuc_state_type next_state;
	logic [dhpuc_pkg::CNT_W-1:0] count;
	logic [dhpuc_pkg::CNT_W-1:0] next_count;
	logic        pend;                                // stored load event
	logic        next_pend;
	logic [11:0] shift_reg;                           // serial shifter

	////////////////////////////////////////////////////////////////////////
	// decoded events
	logic wr_rise;
	logic load_fall;
	logic clear_fall;
	logic rst_fall;
	logic par_mode;
	logic spi_mode;
	logic iface_on;
	always_comb
	begin
		par_mode   = !iface_select;                           // [R19]
		spi_mode   = iface_select && spi_not_twowire;         // [R19]
		iface_on   = (state != dhpuc_pkg::ST_RESET);          // [R14]
		wr_rise    = par_mode && iface_on && !cs_n && wr_n && !wr_n_d;  // [R1] [R18]
		load_fall  = load_d && !load_outputs_n;
		clear_fall = clear_d && !clear_to_code_n;             // [R15]
		rst_fall   = rst_pin_d && !reset_n;                   // [R16]
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb
	begin
		next_state = state;
		next_count = count;
		next_pend  = pend;
		case (state)
			dhpuc_pkg::ST_IDLE:
			begin
				// a data, offset or gain write starts a correction calculation
				if (wr_rise && reg_type_select != dhpuc_pkg::REG_SFR)
				begin
					next_state = dhpuc_pkg::ST_CALC;
					next_count = dhpuc_pkg::CNT_W'(dhpuc_pkg::CALC_CYCLES - 1);
				end
				// a load held over from the update edge is served here too
				if (load_fall || pend)
					next_state = dhpuc_pkg::ST_LOAD;          // [R12] [R13]
			end
			dhpuc_pkg::ST_CALC:
			begin
				if (load_fall)
					next_pend = 1'b1;                         // [R13] [R21]
				if (count == '0)
					next_state = (pend || load_fall) ? dhpuc_pkg::ST_LOAD : dhpuc_pkg::ST_IDLE;
				else
					next_count = count - 1'b1;
			end
			dhpuc_pkg::ST_LOAD:
			begin
				next_pend  = load_fall;                       // set beats clear on the update edge [R13] [R21]
				next_state = dhpuc_pkg::ST_IDLE;
			end
			dhpuc_pkg::ST_CLEAR:
			begin
				if (load_fall)
					next_pend = 1'b1;                         // [R13]
				if (count == '0)
					next_state = (pend || load_fall) ? dhpuc_pkg::ST_LOAD : dhpuc_pkg::ST_IDLE;  // last cycle too [R13]
				else
					next_count = count - 1'b1;
			end
			dhpuc_pkg::ST_RESET:
			begin
				next_pend = 1'b0;                             // loads discarded [R14]
				if (count == '0)
					next_state = dhpuc_pkg::ST_IDLE;          // [R17]
				else
					next_count = count - 1'b1;
			end
			default:
			begin
				next_state = dhpuc_pkg::ST_IDLE;
				next_pend  = 1'b0;
			end
		endcase
		// clear then reset take precedence over normal flow
		if (clear_fall && state != dhpuc_pkg::ST_RESET)
		begin
			next_state = dhpuc_pkg::ST_CLEAR;
			next_count = dhpuc_pkg::CNT_W'(CLEAR_CNT - 1);
		end
		if (rst_fall)                                         // only the edge counts [R17]
		begin
			next_state = dhpuc_pkg::ST_RESET;
			next_count = dhpuc_pkg::CNT_W'(RESET_CNT - 1);
			next_pend  = 1'b0;
		end
	end

	// sequencer registers; power-on behaves like the reset pin
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			state <= dhpuc_pkg::ST_RESET;                     // [R14] [R16]
			count <= dhpuc_pkg::CNT_W'(RESET_CNT - 1);
			pend  <= 1'b0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			pend  <= next_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge history registers
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			wr_n_d    <= 1'b1;
			load_d    <= 1'b1;
			clear_d   <= 1'b1;
			rst_pin_d <= 1'b1;
			sclk_d    <= 1'b0;
		end
		else
		begin
			wr_n_d    <= wr_n;
			load_d    <= load_outputs_n;
			clear_d   <= clear_to_code_n;
			rst_pin_d <= reset_n;
			sclk_d    <= serial_clk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file, written by decoded parallel writes
	always_ff @(posedge clock)
	begin
		if (!nrst || state == dhpuc_pkg::ST_RESET)
		begin
			// defaults restored through the whole sequence [R16]
			for (int i = 0; i < dhpuc_pkg::NUM_CHAN; i++)
			begin
				input_word[i] <= dhpuc_pkg::DATA_RST;
				data_b[i]     <= dhpuc_pkg::DATA_RST;
				offset_reg[i] <= dhpuc_pkg::OFFSET_RST;
				gain_reg[i]   <= dhpuc_pkg::GAIN_RST;
			end
			clear_code  <= dhpuc_pkg::CLEAR_RST;
			toggle_mode <= 1'b0;
		end
		else if (wr_rise)
		begin
			// writes still accepted while calculating [R11]
			case (reg_type_select)                            // [R6]
				dhpuc_pkg::REG_DATA:
				begin
					if (channel_select < 6'(dhpuc_pkg::NUM_CHAN))  // [R5]
					begin
						if (toggle_mode && bank_b_select)     // [R8] [R10]
							data_b[channel_select] <= par_data_bus;  // [R4]
						else
							input_word[channel_select] <= par_data_bus;
					end
				end
				dhpuc_pkg::REG_OFFSET:
				begin
					if (channel_select < 6'(dhpuc_pkg::NUM_CHAN))
						offset_reg[channel_select] <= par_data_bus;
				end
				dhpuc_pkg::REG_GAIN:
				begin
					if (channel_select < 6'(dhpuc_pkg::NUM_CHAN))
						gain_reg[channel_select] <= par_data_bus;
				end
				default:
				begin
					// special function registers
					if (channel_select == dhpuc_pkg::SFR_CLEAR_CODE)
						clear_code <= par_data_bus;
					else if (channel_select == dhpuc_pkg::SFR_TOGGLE)
						toggle_mode <= par_data_bus[0];
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dac registers; offset and gain correction is analog-side, not modelled
	always_ff @(posedge clock)
	begin
		if (!nrst || state == dhpuc_pkg::ST_RESET)
		begin
			for (int i = 0; i < dhpuc_pkg::NUM_CHAN; i++)
				output_word[i] <= dhpuc_pkg::DATA_RST;
			show_b <= 1'b0;
		end
		else if (state == dhpuc_pkg::ST_CLEAR)
		begin
			for (int i = 0; i < dhpuc_pkg::NUM_CHAN; i++)
				output_word[i] <= clear_code;                 // [R15]
		end
		else if (state == dhpuc_pkg::ST_LOAD)                 // never in calc [R11]
		begin
			// toggle flips the phase each load [R9]
			show_b <= toggle_mode ? !show_b : 1'b0;
			for (int i = 0; i < dhpuc_pkg::NUM_CHAN; i++)
				output_word[i] <= (toggle_mode && !show_b) ? data_b[i] : input_word[i];  // [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status outputs and serial shifter
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			busy_n           <= 1'b0;                         // [R14]
			daisy_chain_mode <= 1'b0;
			bus_address      <= 2'h0;
			shift_reg        <= 12'h000;
			serial_out       <= 1'b0;
			serial_out_en    <= 1'b0;
		end
		else
		begin
			busy_n           <= (next_state == dhpuc_pkg::ST_IDLE);  // [R11] [R15] [R17]
			daisy_chain_mode <= spi_mode && chain_enable;            // [R2]
			bus_address      <= {bus_addr_pin_high, bus_addr_pin_low};  // [R3]
			serial_out_en    <= spi_mode && iface_on;                // [R7]
			if (spi_mode && iface_on && sclk_d && !serial_clk)
				shift_reg <= {shift_reg[10:0], serial_in};           // [R20]
			if (spi_mode && iface_on && !sclk_d && serial_clk)
				serial_out <= shift_reg[11];                         // [R7]
		end
	end
endmodule : dhpuc_top

// ===== logic/dhpuc_pkg.sv
package dhpuc_pkg;
	// channel and word geometry
	localparam int DATA_W      = 12;
	localparam int CHAN_SEL_W  = 6;
	localparam int NUM_CHAN    = 40;
	// register type codes on reg_type_select
	localparam logic [1:0] REG_SFR    = 2'h0;
	localparam logic [1:0] REG_DATA   = 2'h3;
	localparam logic [1:0] REG_OFFSET = 2'h2;
	localparam logic [1:0] REG_GAIN   = 2'h1;
	// reset values
	localparam logic [11:0] DATA_RST   = 12'h800;
	localparam logic [11:0] OFFSET_RST = 12'h800;
	localparam logic [11:0] GAIN_RST   = 12'hfff;
	localparam logic [11:0] CLEAR_RST  = 12'h000;
	// sfr addresses used here
	localparam logic [5:0] SFR_CLEAR_CODE = 6'h02;
	localparam logic [5:0] SFR_TOGGLE     = 6'h0c;
	// timing
	localparam int CLK_MHZ        = 25;
	localparam int CLEAR_US       = 35;
	localparam int RESET_US       = 270;
	localparam int CALC_CYCLES    = 16;
	localparam int CLEAR_CYCLES   = CLEAR_US * CLK_MHZ;
	localparam int RESET_CYCLES   = RESET_US * CLK_MHZ;
	localparam int CNT_W          = 14;
	// sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CALC  = 5'h02,
		ST_LOAD  = 5'h04,
		ST_CLEAR = 5'h08,
		ST_RESET = 5'h10
	} dhpuc_state_type;
endpackage : dhpuc_pkg

// ===== sim/dhpuc_assertions.sv
`timescale 1ns/1ns
// port watcher for the host port
module dhpuc_assertions (
	// clock, reset
	input wire logic       clock,
	input wire logic       nrst,
	// modes
	input wire logic       iface_select,
	input wire logic       spi_not_twowire,
	input wire logic       chain_enable,
	input wire logic       bus_addr_pin_low,
	input wire logic       bus_addr_pin_high,
	// parallel write
	input wire logic       cs_n,
	input wire logic       wr_n,
	input wire logic [5:0] channel_select,
	input wire logic [1:0] reg_type_select,
	// control and status
	input wire logic       load_outputs_n,
	input wire logic       clear_to_code_n,
	input wire logic       reset_n,
	input wire logic       busy_n,
	input wire logic       daisy_chain_mode,
	input wire logic [1:0] bus_address,
	input wire logic       serial_out_en
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	////////////////////////////////
	// the reset sequence still runs at release
	a_release_busy: assert property ($rose(nrst) |-> !busy_n)
		else $error("busy high at release");
	// a pin reset keeps busy low for a while
	a_reset_pin: assert property ($fell(reset_n) |-> ##[1:3] !busy_n [*8])
		else $error("busy not held for pin reset");
	// an accepted data write starts the calculation
	a_write_calc: assert property ($rose(wr_n) && !cs_n && !iface_select && busy_n
		&& reg_type_select != 2'h0 && channel_select < 6'h28 |-> ##[1:2] !busy_n)
		else $error("write did not start calculation");
	// clear holds busy low
	a_clear_busy: assert property ($fell(clear_to_code_n) |-> ##[1:3] !busy_n [*8])
		else $error("busy not held for clear");
	// idle load starts an update at once
	a_load_idle: assert property ($fell(load_outputs_n) && busy_n |-> ##[1:3] !busy_n)
		else $error("idle load ignored");
	// chain mode follows the pins
	a_chain_on: assert property ((iface_select && spi_not_twowire && chain_enable) [*2] |-> daisy_chain_mode)
		else $error("chain mode missing");
	// address pins form the bus address; skip the edge after release
	a_bus_addr: assert property ($past(nrst) && $stable({bus_addr_pin_high, bus_addr_pin_low})
		|-> bus_address == {bus_addr_pin_high, bus_addr_pin_low})
		else $error("bus address wrong");
	// serial output floats in parallel mode
	a_serial_float: assert property (!iface_select [*2] |-> !serial_out_en)
		else $error("serial output driven in parallel mode");
endmodule : dhpuc_assertions

bind dhpuc_top dhpuc_assertions u_chk (.clock, .nrst, .iface_select, .spi_not_twowire, .chain_enable,
	.bus_addr_pin_low, .bus_addr_pin_high, .cs_n, .wr_n, .channel_select, .reg_type_select,
	.load_outputs_n, .clear_to_code_n, .reset_n, .busy_n, .daisy_chain_mode, .bus_address, .serial_out_en);

// ===== sim/dhpuc_host.sv
`timescale 1ns/1ns
// host side of the parallel port, drives on falling edges
module dhpuc_host (
	// clock
	input wire logic    clock,
	// parallel bus
	output logic        cs_n,
	output logic        wr_n,
	output logic [11:0] par_data_bus,
	output logic [5:0]  channel_select,
	output logic [1:0]  reg_type_select,
	output logic        bank_b_select
);
	// idle bus at time zero
	initial
	begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		par_data_bus = 12'h000;
		channel_select = 6'h00;
		reg_type_select = 2'h0;
		bank_b_select = 1'b0;
	end
	// one strobed write; sel low keeps the chip deselected
	task write(input logic sel, input logic [1:0] rt, input logic [5:0] ch, input logic [11:0] d, input logic b);
		@(negedge clock);
		cs_n = ~sel;
		reg_type_select = rt;
		channel_select = ch;
		par_data_bus = d;
		bank_b_select = b;
		wr_n = 1'b0;
		@(negedge clock);
		wr_n = 1'b1;
		@(negedge clock);
		@(negedge clock);
		// released lines flip so a stale word is never mistaken for a held one
		cs_n = 1'b1;
		par_data_bus = ~d;
		channel_select = ~ch;
		reg_type_select = ~rt;
	endtask : write
endmodule : dhpuc_host

// ===== sim/dac_host_port_update_control_tb_top.sv
`timescale 1ns/1ns
module dac_host_port_update_control_tb_top;
	// pins and results
	logic clock, nrst, iface_select, spi_not_twowire, chain_enable, bus_addr_pin_low, bus_addr_pin_high;
	logic cs_n, wr_n, bank_b_select, load_outputs_n, clear_to_code_n, reset_n;
	logic busy_n, daisy_chain_mode, serial_out, serial_out_en, serial_clk, serial_in;
	logic [11:0] par_data_bus;
	logic [5:0]  channel_select;
	logic [1:0]  reg_type_select, bus_address;
	logic [11:0] output_word [dhpuc_pkg::NUM_CHAN];
	int          bad_count, total_checks, i;
	localparam logic [11:0] ser_word = 12'ha5c;  // word sent through the serial chain
	// channel, written word, expected output
	typedef struct {logic [5:0] ch; logic [11:0] d; logic [11:0] e;} dhpuc_row_type;
	dhpuc_row_type rows [4] = '{'{6'h00, 12'h123, 12'h123}, '{6'h27, 12'hfff, 12'hfff},
		'{6'h11, 12'h000, 12'h000}, '{6'h05, 12'ha5c, 12'ha5c}};
	always #20 clock = ~clock;
	// short counts keep the run brief
	dhpuc_top #(.RESET_CNT(20), .CLEAR_CNT(10)) DUT (.clock, .nrst, .iface_select, .spi_not_twowire,
		.chain_enable, .bus_addr_pin_low, .bus_addr_pin_high, .cs_n, .wr_n, .par_data_bus, .channel_select,
		.reg_type_select, .bank_b_select, .serial_clk, .serial_in, .serial_out, .serial_out_en,
		.load_outputs_n, .clear_to_code_n, .reset_n, .busy_n, .daisy_chain_mode, .bus_address, .output_word);
	dhpuc_host host (.clock, .cs_n, .wr_n, .par_data_bus, .channel_select, .reg_type_select, .bank_b_select);
	////////////////////////////////
	task check(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	// bounded wait for idle
	task wait_idle;
		for (int n = 0; n < 400 && busy_n !== 1'b1; n++)
			@(negedge clock);
		if (busy_n !== 1'b1)
		begin
			bad_count++;
			$display("wrong value at %0t: busy stuck", $time);
			end_sim;
		end
	endtask : wait_idle
	// pulse load (k 0) or clear (k 1), then let the sequencer react
	task pulse(input int k);
		@(negedge clock);
		{clear_to_code_n, load_outputs_n} = 2'h3 & ~(2'h1 << k);
		@(negedge clock);
		{clear_to_code_n, load_outputs_n} = 2'h3;
		repeat (4) @(negedge clock);
	endtask : pulse
	task put(input logic [1:0] rt, input logic [5:0] ch, input logic [11:0] d, input logic b);
		host.write(1'b1, rt, ch, d, b);
		wait_idle;
	endtask : put
	////////////////////////////////
	initial
	begin
		{clock, nrst, iface_select, spi_not_twowire, chain_enable, bus_addr_pin_low, bus_addr_pin_high} = 7'h00;
		{load_outputs_n, clear_to_code_n, reset_n} = 3'h7;
		{serial_clk, serial_in} = 2'h0;
		bad_count = 0;
		total_checks = 0;
		repeat (16) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
		check({11'h000, busy_n}, 12'h000);
		wait_idle;
		// plain writes then load
		foreach (rows[j])
		begin
			put(dhpuc_pkg::REG_DATA, rows[j].ch, rows[j].d, 1'b0);
			pulse(0);
			wait_idle;
			check(output_word[rows[j].ch], rows[j].e);
		end
		// deselected and serial-mode writes are ignored
		host.write(1'b0, dhpuc_pkg::REG_DATA, 6'h00, 12'hbad, 1'b0);
		check({11'h000, busy_n}, 12'h001);
		iface_select = 1'b1;
		host.write(1'b1, dhpuc_pkg::REG_DATA, 6'h00, 12'hbad, 1'b0);
		iface_select = 1'b0;
		check({11'h000, busy_n}, 12'h001);
		// two loads during calculation give one late update
		host.write(1'b1, dhpuc_pkg::REG_DATA, 6'h03, 12'h3c3, 1'b0);
		pulse(0);
		pulse(0);
		wait_idle;
		repeat (4) @(negedge clock);
		check(output_word[3], 12'h3c3);
		check({11'h000, busy_n}, 12'h001);
		check(output_word[0], 12'h123);
		// write without load leaves the output alone
		put(dhpuc_pkg::REG_DATA, 6'h03, 12'h111, 1'b0);
		check(output_word[3], 12'h3c3);
		put(dhpuc_pkg::REG_GAIN, 6'h03, dhpuc_pkg::GAIN_RST, 1'b0);
		put(dhpuc_pkg::REG_OFFSET, 6'h03, dhpuc_pkg::OFFSET_RST, 1'b0);
		pulse(0);
		wait_idle;
		check(output_word[3], 12'h111);
		// toggle between a and b
		put(dhpuc_pkg::REG_SFR, dhpuc_pkg::SFR_TOGGLE, 12'h001, 1'b0);
		put(dhpuc_pkg::REG_DATA, 6'h07, 12'h0aa, 1'b0);
		put(dhpuc_pkg::REG_DATA, 6'h07, 12'h055, 1'b1);
		pulse(0);
		wait_idle;
		check(output_word[7], 12'h055);
		pulse(0);
		wait_idle;
		check(output_word[7], 12'h0aa);
		put(dhpuc_pkg::REG_SFR, dhpuc_pkg::SFR_TOGGLE, 12'h000, 1'b0);
		put(dhpuc_pkg::REG_DATA, 6'h07, 12'h0f0, 1'b1);
		pulse(0);
		wait_idle;
		check(output_word[7], 12'h0f0);
		// clear to the stored code
		put(dhpuc_pkg::REG_SFR, dhpuc_pkg::SFR_CLEAR_CODE, 12'h5a5, 1'b0);
		pulse(1);
		check({11'h000, busy_n}, 12'h000);
		wait_idle;
		check(output_word[0], 12'h5a5);
		check(output_word[39], 12'h5a5);
		// pin reset, then the held low level is ignored
		reset_n = 1'b0;
		repeat (4) @(negedge clock);
		check({11'h000, busy_n}, 12'h000);
		wait_idle;
		check(output_word[3], dhpuc_pkg::DATA_RST);
		put(dhpuc_pkg::REG_DATA, 6'h03, 12'h777, 1'b0);
		pulse(0);
		wait_idle;
		check(output_word[3], 12'h777);
		// serial mode pins
		iface_select = 1'b1;
		spi_not_twowire = 1'b1;
		for (i = 0; i < 4; i++)
		begin
			{bus_addr_pin_high, bus_addr_pin_low} = i[1:0];
			chain_enable = i[0];
			repeat (3) @(negedge clock);
			check({10'h000, bus_address}, {10'h000, i[1:0]});
			check({11'h000, daisy_chain_mode}, {11'h000, i[0]});
			check({11'h000, serial_out_en}, 12'h001);
		end
		// twelve bits in, then the same word comes out twelve clocks later for chaining
		for (i = 0; i < 24; i++)
		begin
			serial_in  = (i < 12) ? ser_word[11 - i] : 1'b0; // held across the falling edge
			serial_clk = 1'b1;
			repeat (2) @(negedge clock);
			if (i >= 12)
				check({11'h000, serial_out}, {11'h000, ser_word[23 - i]});
			serial_clk = 1'b0;
			repeat (2) @(negedge clock);
		end
		end_sim;
	end
endmodule : dac_host_port_update_control_tb_top
